/* rtl/periodic_timer.sv */
// Ten-bit periodic timer with compare, PWM, single pulse, capture and timer modes on APB.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Mode 00: compare output, clear per clear-select
// R2 - Clear-select low: period match or overflow clears
// R3 - Clear-select high: duty match clears, duty flag only
// R4 - Compare mode, duty zero: overflow, no duty flag
// R5 - Pin changes only on duty flag per function
// R6 - Mode 11: like compare, pin unused
// R7 - Mode 10: PWM, period clears, duty sets width
// R8 - Period 1..1023 ticks, zero gives 1024
// R9 - Duty at or above period: always active
// R10 - Functions 00/01 force pin; polarity bits apply
// R11 - Single pulse: run rise starts pulse
// R12 - Pulse ends on run clear or duty match
// R13 - Single pulse: counter zeroed only by run rise
// R14 - Mode 01: capture edge copies counter to duty
// R15 - Capture function 11 disables capture
// R16 - Capture: free run, period match clears, flags
// R17 - Capture pulses at least two ticks wide
// R18 - Latch within 1.5 ticks, flag after
// R19 - Ten-bit values split low and high bytes
// R20 - Software keeps duty nonzero in compare mode
// R21 - Run rise zeroes counter, resets pin level
// R22 - Capture edge: rising, falling or both
// R23 - Pause freezes counter, resume continues
// R24 - Counter advances one per selected tick
// R25 - Flags stay set until software clears
module periodic_timer #(
	parameter int SUB_DIV_UNUSED = 0
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        captureInputPin,
	output logic             timerOutputPin,
	output logic             timerOutputEn,
	output logic             dutyMatchFlag,
	output logic             periodMatchFlag
);
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        pause_r;
	logic [2:0]  clkSel_r;
	logic        run_r;
	logic        runPrev_r;
	logic [1:0]  mode_r;
	logic [1:0]  pinFn_r;
	logic        outLevel_r;
	logic        outInv_r;
	logic        capSrc_r;
	logic        clrSel_r;
	logic [9:0]  duty_r;
	logic [9:0]  period_r;
	logic [9:0]  cnt_r;
	logic        flagA_r;
	logic        flagP_r;
	logic [7:0]  psc_r;
	logic        capSync1_r;
	logic        capSync2_r;
	logic        capPrev_r;
	logic        capPend_r;
	logic        capFlag_r;
	logic        cmpOut_r;
	logic        pin_r;
	logic        pinEn_r;

	// Bus decode; the access phase lasts two cycles so read data can come from a flop.
	wire         access = psel & penable;
	wire         done = access & pready_r;
	wire         wrDone = done & pwrite;
	wire         hitC0 = paddr == periodic_timer_pkg::OFS_CTRL0;
	wire         hitC1 = paddr == periodic_timer_pkg::OFS_CTRL1;
	wire         hitAL = paddr == periodic_timer_pkg::OFS_DUTY_LO;
	wire         hitAH = paddr == periodic_timer_pkg::OFS_DUTY_HI;
	wire         hitPL = paddr == periodic_timer_pkg::OFS_PER_LO;
	wire         hitPH = paddr == periodic_timer_pkg::OFS_PER_HI;
	wire         hitNL = paddr == periodic_timer_pkg::OFS_CNT_LO;
	wire         hitNH = paddr == periodic_timer_pkg::OFS_CNT_HI;
	wire         hitF = paddr == periodic_timer_pkg::OFS_FLAGS;
	wire         mapped = hitC0 | hitC1 | hitAL | hitAH | hitPL | hitPH | hitNL | hitNH | hitF;
	wire         wrC0 = wrDone & hitC0;
	wire         wrC1 = wrDone & hitC1;
	wire         wrAL = wrDone & hitAL;
	wire         wrAH = wrDone & hitAH;
	wire         wrPL = wrDone & hitPL;
	wire         wrPH = wrDone & hitPH;
	wire         wrF = wrDone & hitF;

	wire [7:0]   ctrl0Rd = {pause_r, clkSel_r, run_r, 3'h0};
	wire [7:0]   ctrl1Rd = {mode_r, pinFn_r, outLevel_r, outInv_r, capSrc_r, clrSel_r};
	wire [7:0]   flagRd = {6'h00, flagP_r, flagA_r};
	// R19
	wire [7:0]   rdByte =
		hitC0 ? ctrl0Rd :
		hitC1 ? ctrl1Rd :
		hitAL ? duty_r[7:0] :
		hitAH ? {6'h00, duty_r[9:8]} :
		hitPL ? period_r[7:0] :
		hitPH ? {6'h00, period_r[9:8]} :
		hitNL ? cnt_r[7:0] :
		hitNH ? {6'h00, cnt_r[9:8]} :
		hitF ? flagRd : periodic_timer_pkg::BYTE_RST;

	// pready falls in the cycle after it rises; a master that keeps penable high
	// sees it rise again two cycles later, as a second strobe for one transfer.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= periodic_timer_pkg::WORD_ZERO;
		end else begin
			pready_r <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~mapped;
			prdata_r <= {24'h000000, rdByte};
		end
	end

	// Timer tick from the clock-select field; the sub-clock source is a fixed divider here.
	// The prescaler runs freely, so the first tick after a run rise can come early by up to
	// one division; use the undivided clock where the first period must be exact.
	wire [7:0]   pscNxt = psc_r + 8'h01;
	wire         tick =
		(clkSel_r == periodic_timer_pkg::CK_DIV1) |
		((clkSel_r == periodic_timer_pkg::CK_DIV4) &
			((psc_r & periodic_timer_pkg::PSC_M4) == periodic_timer_pkg::PSC_M4)) |
		((clkSel_r == periodic_timer_pkg::CK_DIV16) &
			((psc_r & periodic_timer_pkg::PSC_M16) == periodic_timer_pkg::PSC_M16)) |
		((clkSel_r == periodic_timer_pkg::CK_DIV64) &
			((psc_r & periodic_timer_pkg::PSC_M64) == periodic_timer_pkg::PSC_M64)) |
		(((clkSel_r == periodic_timer_pkg::CK_SUB0) |
			(clkSel_r == periodic_timer_pkg::CK_SUB1)) &
			(psc_r == periodic_timer_pkg::PSC_MSUB));

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			psc_r <= periodic_timer_pkg::BYTE_RST;
		end else begin
			psc_r <= pscNxt;
		end
	end

	// Mode decode.
	// Single pulse shares the PWM mode code and is told apart by the pin function alone.
	wire         isCmp = mode_r == periodic_timer_pkg::MODE_CMP;
	wire         isTc = mode_r == periodic_timer_pkg::MODE_TC;
	wire         isCap = mode_r == periodic_timer_pkg::MODE_CAP;
	wire         isPwmFam = mode_r == periodic_timer_pkg::MODE_PWM;
	wire         isSingle = isPwmFam & (pinFn_r == periodic_timer_pkg::PF_11);
	wire         isPwm = isPwmFam & ~isSingle;
	wire         isCmpLike = isCmp | isTc; // R6

	wire         runRise = run_r & ~runPrev_r;
	// The run rise cycle only zeroes the counter. Holding the step off there keeps a stale
	// count from raising a flag or ending a single pulse at the instant that it starts.
	wire         step = run_r & ~runRise & ~pause_r & tick; // R21 R23 R24
	wire         atMax = cnt_r == periodic_timer_pkg::CNT_MAX;
	wire         perZero = period_r == periodic_timer_pkg::CNT_ZERO;
	wire         dutyZero = duty_r == periodic_timer_pkg::CNT_ZERO;
	// A period of zero is compared with the top count, so the counter wraps there.
	wire         perHit = perZero ? atMax : (cnt_r == period_r);
	wire         dutyHit = cnt_r == duty_r;
	wire [9:0]   perLast = period_r - periodic_timer_pkg::CNT_ONE;
	wire         pwmEnd = perZero ? atMax : (cnt_r == perLast); // R8
	wire [9:0]   cntInc = cnt_r + periodic_timer_pkg::CNT_ONE;

	// Compare and timer modes.
	// A duty of zero never matches here; software must keep it nonzero in compare mode.
	wire         cmpA = isCmpLike & dutyHit & ~dutyZero; // R4
	wire         cmpP = isCmpLike & ~clrSel_r & perHit; // R2 R3
	wire         cmpClr = clrSel_r ? cmpA : cmpP; // R1 R2 R3
	// PWM mode ignores clear-select.
	wire         pwmA = isPwm & dutyHit; // R7
	wire         pwmP = isPwm & pwmEnd; // R7
	// Single pulse: the duty match ends the pulse and drops the run bit.
	wire         spA = isSingle & dutyHit; // R12
	// Capture: counter free runs, period match wraps it.
	wire         capP = isCap & perHit; // R16

	// Single pulse has no clear term: after its duty match the count stays put until the
	// next run rise, so software can read how far it got.
	wire         evA = step & (cmpA | pwmA | spA);
	wire         evP = step & (cmpP | pwmP | capP);
	wire         cntClr = (isCmpLike & cmpClr) | pwmP | capP;
	wire [9:0]   cntNxt =
		runRise ? periodic_timer_pkg::CNT_ZERO :
		~step ? cnt_r :
		cntClr ? periodic_timer_pkg::CNT_ZERO : cntInc;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= periodic_timer_pkg::CNT_ZERO;
		end else begin
			cnt_r <= cntNxt; // R13 R21 R23 R24
		end
	end

	// Control registers. A software write to the run bit beats the hardware clear.
	wire         hwRunClr = evA & isSingle; // R12
	wire         runNxt = wrC0 ? pwdata[periodic_timer_pkg::BIT_RUN] : (run_r & ~hwRunClr);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			run_r <= 1'b0;
			runPrev_r <= 1'b0;
		end else begin
			run_r <= runNxt;
			runPrev_r <= run_r;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pause_r <= 1'b0;
			clkSel_r <= periodic_timer_pkg::CK_DIV4;
		end else if (wrC0) begin
			pause_r <= pwdata[periodic_timer_pkg::BIT_PAUSE];
			clkSel_r <= pwdata[periodic_timer_pkg::BIT_CKS_HI:periodic_timer_pkg::BIT_CKS_LO];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_r <= periodic_timer_pkg::MODE_CMP;
			pinFn_r <= periodic_timer_pkg::PF_00;
			outLevel_r <= 1'b0;
			outInv_r <= 1'b0;
			capSrc_r <= 1'b0;
			clrSel_r <= 1'b0;
		end else if (wrC1) begin
			mode_r <= pwdata[periodic_timer_pkg::BIT_MODE_HI:periodic_timer_pkg::BIT_MODE_LO];
			pinFn_r <= pwdata[periodic_timer_pkg::BIT_PF_HI:periodic_timer_pkg::BIT_PF_LO];
			outLevel_r <= pwdata[periodic_timer_pkg::BIT_OLVL];
			outInv_r <= pwdata[periodic_timer_pkg::BIT_INV];
			capSrc_r <= pwdata[periodic_timer_pkg::BIT_CAPSRC];
			clrSel_r <= pwdata[periodic_timer_pkg::BIT_CLRSEL];
		end
	end

	// Capture input: two-stage synchroniser, then an edge detector on the second stage.
	// A level held for less than one tick can be lost here, so the source must hold each
	// level at least that long.
	wire         capRise = capSync2_r & ~capPrev_r;
	wire         capFall = ~capSync2_r & capPrev_r;
	wire         capEdge =
		(pinFn_r == periodic_timer_pkg::PF_00) ? capRise :
		(pinFn_r == periodic_timer_pkg::PF_01) ? capFall :
		(pinFn_r == periodic_timer_pkg::PF_10) ? (capRise | capFall) : 1'b0; // R15 R22
	// The reserved trigger source captures nothing.
	wire         capArm = isCap & run_r & ~capSrc_r & capEdge; // R14
	// The pending edge is latched on the next tick, so the copy lands within one tick.
	wire         capLatch = (capPend_r | capArm) & tick; // R18
	// The pending edge is dropped the cycle after capture mode is left, so a stale edge can still land on a tick in that cycle.
	wire         capPendNxt = (capPend_r | capArm) & ~tick & isCap;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			capSync1_r <= 1'b0;
			capSync2_r <= 1'b0;
			capPrev_r <= 1'b0;
			capPend_r <= 1'b0;
			capFlag_r <= 1'b0;
		end else begin
			capSync1_r <= captureInputPin;
			capSync2_r <= capSync1_r;
			capPrev_r <= capSync2_r;
			capPend_r <= capPendNxt;
			capFlag_r <= capLatch; // R18
		end
	end

	// Compare values. A capture in the same cycle as a software write takes the register.
	wire [9:0]   dutyWr = {
		wrAH ? pwdata[periodic_timer_pkg::BIT_HI_TOP:0] : duty_r[9:8],
		wrAL ? pwdata[periodic_timer_pkg::BIT_LO_TOP:0] : duty_r[7:0]}; // R19
	wire [9:0]   dutyNxt = capLatch ? cnt_r : dutyWr; // R14
	wire [9:0]   periodNxt = {
		wrPH ? pwdata[periodic_timer_pkg::BIT_HI_TOP:0] : period_r[9:8],
		wrPL ? pwdata[periodic_timer_pkg::BIT_LO_TOP:0] : period_r[7:0]}; // R19

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			duty_r <= periodic_timer_pkg::CNT_ZERO;
			period_r <= periodic_timer_pkg::CNT_ZERO;
		end else begin
			duty_r <= dutyNxt;
			period_r <= periodNxt;
		end
	end

	// Flags are write-one-to-clear; a new event in the clearing cycle keeps the flag set.
	// Bits above the two flags are ignored on write and read as zero.
	wire         setA = evA | capFlag_r; // R14 R18
	wire         setP = evP;
	wire         clrA = wrF & pwdata[periodic_timer_pkg::BIT_FLAG_DUTY];
	wire         clrP = wrF & pwdata[periodic_timer_pkg::BIT_FLAG_PER];
	wire         flagANxt = (flagA_r & ~clrA) | setA; // R25
	wire         flagPNxt = (flagP_r & ~clrP) | setP; // R25

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flagA_r <= 1'b0;
			flagP_r <= 1'b0;
		end else begin
			flagA_r <= flagANxt;
			flagP_r <= flagPNxt;
		end
	end

	// Compare output level; the run rise sets it and duty matches move it.
	// High or low only shows a change when it differs from the level set at the run rise.
	wire         cmpOutAct =
		(pinFn_r == periodic_timer_pkg::PF_01) ? 1'b0 :
		(pinFn_r == periodic_timer_pkg::PF_10) ? 1'b1 :
		(pinFn_r == periodic_timer_pkg::PF_11) ? ~cmpOut_r : cmpOut_r;
	wire         cmpOutNxt =
		runRise ? outLevel_r :
		(evA & isCmp) ? cmpOutAct : cmpOut_r; // R5 R21

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmpOut_r <= 1'b0;
		end else begin
			cmpOut_r <= cmpOutNxt;
		end
	end

	// PWM active phase; a duty at or beyond the period holds it active throughout.
	wire [10:0]  perLen = perZero ? periodic_timer_pkg::PWM_FULL : {1'b0, period_r};
	wire         pwmFull = {1'b0, duty_r} >= perLen; // R9
	wire         pwmAct = pwmFull | (cnt_r < duty_r);
	wire         pwmSel =
		(pinFn_r == periodic_timer_pkg::PF_00) ? 1'b0 :
		(pinFn_r == periodic_timer_pkg::PF_01) ? 1'b1 :
		(pinFn_r == periodic_timer_pkg::PF_10) ? pwmAct : run_r; // R10 R11 R12
	// Active-level bit picks polarity of the active phase.
	// Changing the pin function while running can leave a partial period on the pin.
	wire         pwmLvl = pwmSel ? outLevel_r : ~outLevel_r; // R10
	wire         pinRaw = isCmp ? cmpOut_r : pwmLvl;
	wire         pinNxt = (isCmp | isPwmFam) & (pinRaw ^ outInv_r); // R10
	// Modes without an output park the pin low and drop the enable, freeing it for other uses.
	wire         pinEnNxt = isCmp | isPwmFam; // R6

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_r <= 1'b0;
			pinEn_r <= 1'b0;
		end else begin
			pin_r <= pinNxt;
			pinEn_r <= pinEnNxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign timerOutputPin = pin_r;
	assign timerOutputEn = pinEn_r;
	assign dutyMatchFlag = flagA_r;
	assign periodMatchFlag = flagP_r;
endmodule : periodic_timer

`default_nettype wire

/* rtl/periodic_timer_pkg.sv */
// Constants shared by the periodic timer: register map, field positions, modes and codes.
package periodic_timer_pkg;
	localparam int CNT_W = 10;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DUTY_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DUTY_HI = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PER_LO = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PER_HI = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h20;

	localparam int BIT_PAUSE = 7;
	localparam int BIT_CKS_HI = 6;
	localparam int BIT_CKS_LO = 4;
	localparam int BIT_RUN = 3;
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_PF_HI = 5;
	localparam int BIT_PF_LO = 4;
	localparam int BIT_OLVL = 3;
	localparam int BIT_INV = 2;
	localparam int BIT_CAPSRC = 1;
	localparam int BIT_CLRSEL = 0;
	localparam int BIT_FLAG_DUTY = 0;
	localparam int BIT_FLAG_PER = 1;
	localparam int BIT_HI_TOP = 1;
	localparam int BIT_LO_TOP = 7;

	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC = 2'h3;

	localparam logic [1:0] PF_00 = 2'h0;
	localparam logic [1:0] PF_01 = 2'h1;
	localparam logic [1:0] PF_10 = 2'h2;
	localparam logic [1:0] PF_11 = 2'h3;

	localparam logic [2:0] CK_DIV4 = 3'h0;
	localparam logic [2:0] CK_DIV1 = 3'h1;
	localparam logic [2:0] CK_DIV16 = 3'h2;
	localparam logic [2:0] CK_DIV64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;

	localparam logic [7:0] PSC_M4 = 8'h03;
	localparam logic [7:0] PSC_M16 = 8'h0F;
	localparam logic [7:0] PSC_M64 = 8'h3F;
	localparam logic [7:0] PSC_MSUB = 8'hFF;

	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
	localparam logic [CNT_W:0] PWM_FULL = 11'h400;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
endpackage : periodic_timer_pkg

/* tb/periodic_timer_assertions.sv */
// Concurrent checks on the periodic timer's ports.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_assertions (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        captureInputPin,
	input wire logic        timerOutputPin,
	input wire logic        timerOutputEn,
	input wire logic        dutyMatchFlag,
	input wire logic        periodMatchFlag
);
	logic [7:0] ctl1_r;
	wire        wrDone = psel && penable && pready && pwrite;
	wire        clrW   = wrDone && paddr == periodic_timer_pkg::OFS_FLAGS;
	wire        mapped = paddr <= periodic_timer_pkg::OFS_FLAGS && paddr[1:0] == 2'h0;
	// The three high-byte registers are the mapped words with bit 2 set above the first two.
	wire        hiByte = mapped && paddr[2] && paddr[4:3] != 2'h0;
	wire        pinFree = ctl1_r[6];
	wire        noPer = ctl1_r[0] && ctl1_r[7] == ctl1_r[6];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// A shadow of the mode bits is kept from the bus, since the ports do not show them.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			ctl1_r <= 8'h00;
		else if (wrDone && paddr == periodic_timer_pkg::OFS_CTRL1)
			ctl1_r <= pwdata[7:0];
	end
	a_ready_second: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_read_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && !(hiByte && prdata[7:2] != 6'h0) && !(pslverr && prdata != 32'h0))
		else $error("unused read bits not zero");
	a_duty_sticky: assert property ($fell(dutyMatchFlag) |-> $past(clrW && pwdata[0]))
		else $error("duty flag dropped without clear");
	a_period_sticky: assert property ($fell(periodMatchFlag) |-> $past(clrW && pwdata[1]))
		else $error("period flag dropped without clear");
	a_pin_unused: assert property (pinFree && $past(pinFree) |-> !timerOutputEn && !timerOutputPin)
		else $error("pin used in a mode without output");
	a_no_period_flag: assert property ($rose(periodMatchFlag) |-> !(noPer && $past(noPer)))
		else $error("period flag with clear on duty");
endmodule : periodic_timer_assertions
`default_nettype wire

/* tb/capture_source.sv */
// Pulse source for the capture pin; each level is held a minimum time before it changes.
`timescale 1ns/1ps
`default_nettype none
module capture_source #(
	parameter int MIN_HOLD = 16
) (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic wantLevel,
	output logic      pinLevel
);
	logic [7:0] held_r;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pinLevel <= 1'b0;
			held_r <= 8'h00;
		end else if (wantLevel != pinLevel && held_r >= MIN_HOLD) begin
			pinLevel <= wantLevel;
			held_r <= 8'h00;
		end else if (held_r != 8'hFF) begin
			held_r <= held_r + 8'h01;
		end
	end
endmodule : capture_source
`default_nettype wire

/* tb/periodic_timer_tb_top.sv */
// Self-checking bench for the periodic timer over APB.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_tb_top;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic        wantLevel = 1'b0;
	logic [31:0] seed = 32'h2305;
	logic [31:0] q;
	logic [31:0] v;
	logic [31:0] c0;
	logic        lastErr;
	logic [9:0]  du;
	logic [9:0]  pe;
	int          n_fail = 0;
	int          num_checks = 0;
	int          len;
	int          n;
	wire  [31:0] prdata;
	wire         pready, pslverr, capPin, outPin, outEn, dFlag, pFlag;
	always #2.5 clk_sys = ~clk_sys;
	periodic_timer dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .captureInputPin(capPin), .timerOutputPin(outPin),
		.timerOutputEn(outEn), .dutyMatchFlag(dFlag), .periodMatchFlag(pFlag));
	capture_source src (.clk_sys(clk_sys), .nrst(nrst), .wantLevel(wantLevel), .pinLevel(capPin));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic int expHigh(input int duty, input int per);
		return (duty >= per) ? per : duty;
	endfunction : expHigh
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Every transfer starts one edge later, so psel is never assigned twice in one step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			give_verdict();
		end
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic waitHigh(input logic per, input int lim);
		int k;
		k = 0;
		while ((per ? pFlag : dFlag) !== 1'b1 && k < lim) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= lim) begin
			n_fail++;
			give_verdict();
		end
	endtask : waitHigh
	task automatic cfg(input logic [7:0] c1, input logic [9:0] d, input logic [9:0] p,
		input logic [2:0] ck);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, 8'h00);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL1, c1);
		apb(1'b1, periodic_timer_pkg::OFS_DUTY_LO, d[7:0]);
		apb(1'b1, periodic_timer_pkg::OFS_DUTY_HI, {6'h00, d[9:8]});
		apb(1'b1, periodic_timer_pkg::OFS_PER_LO, p[7:0]);
		apb(1'b1, periodic_timer_pkg::OFS_PER_HI, {6'h00, p[9:8]});
		apb(1'b1, periodic_timer_pkg::OFS_FLAGS, 8'h03);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, {1'b0, ck, 4'h8});
	endtask : cfg
	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int a = 8; a <= 20; a += 4) begin
			apb(1'b0, 8'(a), 8'h00);
			check("reset value", q, 32'h00000000);
			v = rnd();
			apb(1'b1, 8'(a), v[7:0]);
			apb(1'b0, 8'(a), 8'h00);
			check("byte readback", q, a[2] ? {30'h0, v[1:0]} : {24'h0, v[7:0]});
		end
		apb(1'b0, 8'h24, 8'h00);
		check("unmapped error", {31'h0, lastErr}, 32'h1);
		cfg(8'h20, 10'd200, 10'd300, 3'h1);
		check("initial pin", {31'h0, outPin}, 32'h0);
		waitHigh(1'b0, 2000);
		repeat (2) @(posedge clk_sys);
		check("pin on duty", {31'h0, outPin}, 32'h1);
		check("no period yet", {31'h0, pFlag}, 32'h0);
		waitHigh(1'b1, 2000);
		check("pin on period", {31'h0, outPin}, 32'h1);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, 8'h10);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, 8'h18);
		repeat (3) @(posedge clk_sys);
		check("pin restored", {31'h0, outPin}, 32'h0);
		cfg(8'h01, 10'd8, 10'd2, 3'h1);
		repeat (100) @(posedge clk_sys);
		check("duty clear flag", {30'h0, pFlag, dFlag}, 32'h1);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		check("count bound", {31'h0, q <= 32'd8}, 32'h1);
		cfg(8'hC0, 10'd5, 10'd9, 3'h1);
		repeat (60) @(posedge clk_sys);
		check("timer flags", {29'h0, outEn, pFlag, dFlag}, 32'h3);
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			pe = (i == 0) ? 10'd0 : 10'(v[5:0]) + 10'd2;
			len = (pe == 10'd0) ? 1024 : int'(pe);
			du = (i == 1) ? pe + 10'd1 : 10'(v[15:8] % len);
			cfg(8'hA8 | {7'h00, v[20]}, du, pe, 3'h1);
			repeat (8) @(posedge clk_sys);
			n = 0;
			for (int c = 0; c < 2 * len; c++) begin
				@(posedge clk_sys);
				n += (outPin === 1'b1);
			end
			check("pwm high count", n, 2 * expHigh(du, len));
		end
		for (int k = 0; k < 4; k++) begin
			cfg({3'h4, k[0], 1'b1, k[1], 2'h0}, 10'd3, 10'd9, 3'h1);
			repeat (8) @(posedge clk_sys);
			check("forced pin", {31'h0, outPin}, {31'h0, k[1] ^ k[0]});
		end
		cfg(8'hB8, 10'd40, 10'd5, 3'h1);
		repeat (2) @(posedge clk_sys);
		check("pulse lead", {31'h0, outPin}, 32'h1);
		waitHigh(1'b0, 500);
		repeat (2) @(posedge clk_sys);
		check("pulse trail", {31'h0, outPin}, 32'h0);
		apb(1'b0, periodic_timer_pkg::OFS_CTRL0, 8'h00);
		check("run cleared", {31'h0, q[3]}, 32'h0);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		c0 = q;
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		check("count kept", q, c0);
		check("period unused", {31'h0, q > 32'd5}, 32'h1);
		cfg(8'hC0, 10'd0, 10'd0, 3'h1);
		repeat (1100) @(posedge clk_sys);
		check("overflow wrap", {30'h0, pFlag, dFlag}, 32'h2);
		cfg(8'h70, 10'd0, 10'd6, 3'h1);
		repeat (40) @(posedge clk_sys);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		check("capture wrap", {29'h0, q <= 32'd6, pFlag, dFlag}, 32'h6);
		for (int f = 0; f < 4; f++) begin
			cfg({2'h1, 2'(f), 4'h0}, 10'd0, 10'd0, 3'h0);
			apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
			c0 = q;
			wantLevel <= 1'b1;
			repeat (24) @(posedge clk_sys);
			check("rise capture", {31'h0, dFlag}, {31'h0, f == 0 || f == 2});
			if (f == 0) begin
				apb(1'b0, periodic_timer_pkg::OFS_DUTY_LO, 8'h00);
				check("captured value", {31'h0, (q - c0) < 32'd16}, 32'h1);
			end
			apb(1'b1, periodic_timer_pkg::OFS_FLAGS, 8'h03);
			wantLevel <= 1'b0;
			repeat (24) @(posedge clk_sys);
			check("fall capture", {31'h0, dFlag}, {31'h0, f == 1 || f == 2});
		end
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, 8'h88);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		c0 = q;
		repeat (16) @(posedge clk_sys);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		check("paused count", q, c0);
		apb(1'b1, periodic_timer_pkg::OFS_CTRL0, 8'h08);
		repeat (16) @(posedge clk_sys);
		apb(1'b0, periodic_timer_pkg::OFS_CNT_LO, 8'h00);
		check("resumed count", {31'h0, q != c0}, 32'h1);
		give_verdict();
	end
endmodule : periodic_timer_tb_top
bind periodic_timer periodic_timer_assertions chk (.clk_sys(clk_sys), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .captureInputPin(captureInputPin),
	.timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn),
	.dutyMatchFlag(dutyMatchFlag), .periodMatchFlag(periodMatchFlag));
`default_nettype wire
